// >>> core/mopx_pkg.sv
/*
  Constants, register map, selector codes and types for the micro-op
  execution unit. Assumes a single 125 MHz clock and an AHB-Lite bus.
*/
`default_nettype none
package mopx_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_OP = 8'h00;
  localparam logic [7:0] A_ARG = 8'h04;
  localparam logic [7:0] A_LIT24 = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_X = 8'h10;
  localparam logic [7:0] A_Y = 8'h14;
  localparam logic [7:0] A_T = 8'h18;
  localparam logic [7:0] A_L = 8'h1C;
  localparam logic [7:0] A_FA = 8'h20;
  localparam logic [7:0] A_FB = 8'h24;
  localparam logic [7:0] A_FL = 8'h28;
  localparam logic [7:0] A_CPL = 8'h2C;
  localparam logic [7:0] A_MAR = 8'h30;
  localparam logic [7:0] A_TAS = 8'h34;
  localparam logic [7:0] A_BR = 8'h38;
  localparam logic [7:0] A_LR = 8'h3C;
  localparam logic [7:0] A_NIB = 8'h40;
  localparam logic [7:0] A_NXOR = 8'h44;
  localparam logic [7:0] A_CP = 8'h48;
  // ----------------------------------------------------------------
  // Operand selector codes (nibble registers at 24..31)
  // ----------------------------------------------------------------
  localparam logic [4:0] S_X = 5'h00;
  localparam logic [4:0] S_Y = 5'h01;
  localparam logic [4:0] S_T = 5'h02;
  localparam logic [4:0] S_L = 5'h03;
  localparam logic [4:0] S_MAR = 5'h04;
  localparam logic [4:0] S_BR = 5'h05;
  localparam logic [4:0] S_LR = 5'h06;
  localparam logic [4:0] S_FA = 5'h07;
  localparam logic [4:0] S_FB = 5'h08;
  localparam logic [4:0] S_FL = 5'h09;
  localparam logic [4:0] S_TAS = 5'h0A;
  localparam logic [4:0] S_CP = 5'h0B;
  localparam logic [4:0] S_CPL = 5'h0C;
  localparam logic [4:0] S_UNIT = 5'h0D;
  localparam logic [4:0] S_CMD = 5'h0F;
  localparam logic [4:0] S_NXT = 5'h10;
  localparam logic [4:0] S_NIB = 5'h18;
  localparam logic [2:0] N_BCN = 3'h0;
  localparam logic [2:0] N_OPERAND_STATE = 3'h3;
  localparam logic [2:0] N_CU = 3'h4;
  localparam logic [3:0] CU_BCD = 4'h1;
  // ----------------------------------------------------------------
  // Argument word fields
  // ----------------------------------------------------------------
  localparam int F_SEL = 0;
  localparam int F_VAR = 5;
  localparam int F_LIT = 8;
  localparam int F_AUX = 16;
  localparam int F_DIR = 21;
  localparam int F_ROT = 22;
  localparam int F_YSEL = 23;
  localparam int ST_BUSY_B = 0;
  localparam int ST_SKIP_B = 1;
  localparam int ST_REF_B = 2;
  localparam int ST_OVR_B = 3;
  // ----------------------------------------------------------------
  // Widths, masks and cycle counts
  // ----------------------------------------------------------------
  localparam logic [4:0] FULL_W = 5'h18;
  localparam logic [23:0] M24 = 24'hFFFFFF;
  localparam logic [23:0] M16 = 24'h00FFFF;
  localparam logic [23:0] M8 = 24'h0000FF;
  localparam logic [23:0] M5 = 24'h00001F;
  localparam logic [23:0] M4 = 24'h00000F;
  localparam logic [23:0] MAR_STEP = 24'h000001;
  localparam logic [3:0] C_BASE = 4'h2;
  localparam logic [3:0] C_BCD = 4'h1;
  localparam logic [3:0] C_TAKEN = 4'h2;
  localparam logic [3:0] C_MAR = 4'h2;
  localparam logic [3:0] C_MEM = 4'h8;
  localparam logic [3:0] C_L24 = 4'h6;
  localparam logic [3:0] C_SHT = 4'h3;
  localparam logic [3:0] C_BR = 4'h4;
  localparam logic [3:0] C_CALL = 4'h5;
  localparam logic [3:0] C_DSH = 4'h6;
  localparam logic [3:0] C_ONE = 4'h1;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_MOVE = 4'h1, OP_NIB = 4'h2, OP_BT0 = 4'h3,
    OP_BT1 = 4'h4, OP_SKT = 4'h5, OP_MEM = 4'h6, OP_L8 = 4'h7,
    OP_L24 = 4'h8, OP_SHT = 4'h9, OP_EXT = 4'hA, OP_BR = 4'hB,
    OP_CALL = 4'hC, OP_SXY = 4'hD, OP_DSH = 4'hE, OP_RSV = 4'hF
  } mopx_op_t;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} mopx_st_t;
  typedef struct packed {
    logic [23:0] x, y, t, l, mar, br, lr, fa, fb, fl, stack_top, cp, container_length;
    logic [15:0][23:0] stk;
    logic [3:0] sp;
    logic [7:0][3:0] nib;
    logic [15:0] nxor;
    logic [23:0] arg, lit24;
    mopx_st_t st;
    logic [3:0] cnt;
    logic skip, refused, ovr;
    logic pend_rd;
    logic [4:0] pend_sel, pend_len;
    logic dph, dwr, hready;
    logic [7:0] dadr;
    logic [31:0] hrdata;
    logic mem_req, mem_wr, mem_dir;
    logic [23:0] mem_addr, mem_wdata;
    logic [4:0] mem_len;
  } mopx_state_t;
endpackage
`default_nettype wire

// >>> core/mopx_unit.sv
/*
  Micro-op execution unit: executes one micro-operation per start, keeps
  the operand registers, return stack and nibble registers, and answers
  as an AHB-Lite slave. Assumes a memory that answers a field request
  within six clocks, on the same clock.
*/
// The AHB-Lite register port and the address map were decided locally.
// Functional notes
// - Unit, container unit, command port refused as source
// - Next-op destination ORs into following op only
// - Nibble variants 0-3: set, and, or, xor
// - Variants 4/6: add/subtract mod 16, no skip
// - Variants 5/7: skip on carry/borrow
// - Nibble op two clocks, two more if skipping
// - Bit test branches on zero or one
// - Tests two clocks, plus BCD and taken
// - Masked skip any, all, equal and inverses
// - Variants 3/7 also clear masked bits
// - Zero mask: any false (true on variant 7), all true
// - Clearing variants refuse four condition nibbles
// - Memory field move by field address, length
// - Count variant on field registers, eight clocks
// - Literal 8 move, two clocks, plus micro address
// - Literal 24 move truncated, six clocks
// - Shift barrel source left into destination
// - Extract rotated field into coded register
// - Relative branch by signed words, four clocks
// - Relative call pushes return, five clocks
// - Shift or rotate first or second operand
// - Double shift of 48 bits, six clocks
`timescale 1ns/1ps
`default_nettype none
module mopx_unit
  import mopx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output logic MEM_REQ,
  output logic MEM_WRITE,
  output logic MEM_DIR,
  output logic [23:0] MEM_ADDR,
  output logic [4:0] MEM_LEN,
  output logic [23:0] MEM_WDATA,
  input wire logic [23:0] MEM_RDATA,
  output logic BUSY
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] src_val(mopx_state_t s, logic [4:0] sel);
    logic [23:0] v;
    v = '0;
    if (sel >= S_NIB) v = {20'h0, s.nib[sel[2:0]]};
    else if (sel == S_X) v = s.x;
    else if (sel == S_Y) v = s.y;
    else if (sel == S_T) v = s.t;
    else if (sel == S_L) v = s.l;
    else if (sel == S_MAR) v = s.mar;
    else if (sel == S_BR) v = s.br;
    else if (sel == S_LR) v = s.lr;
    else if (sel == S_FA) v = s.fa;
    else if (sel == S_FB) v = s.fb;
    else if (sel == S_FL) v = s.fl;
    else if (sel == S_TAS) v = s.stack_top;
    else if (sel == S_CP) v = s.cp;
    else if (sel == S_CPL) v = s.container_length;
    return v; // Next-op source reads 24 zeroes
  endfunction

  function automatic logic [23:0] wmask(logic [4:0] sel);
    logic [23:0] m;
    m = M24;
    if (sel >= S_NIB) m = M4;
    else if (sel == S_CP) m = M8;
    else if (sel == S_FL) m = M16;
    else if (sel == S_CPL) m = M5;
    return m;
  endfunction

  function automatic logic [23:0] lowmask(logic [4:0] w);
    logic [47:0] one;
    one = 48'h1;
    return (w >= FULL_W) ? M24 : 24'((one << w) - one);
  endfunction

  function automatic logic [23:0] rotl(logic [23:0] v, logic [4:0] c);
    logic [4:0] k;
    logic [47:0] d;
    k = (c >= FULL_W) ? 5'(c - FULL_W) : c;
    d = {v, v} << k;
    return d[47:24];
  endfunction

  mopx_state_t r, n;
  logic [23:0] a;
  logic [4:0] sel, aux, cnt5, flen;
  logic [2:0] vr;
  logic [7:0] lit;
  logic [23:0] sv, mask, dispx, wr_data;
  logic [4:0] wr_sel;
  logic wr_en, start, skip, taken, refuse, bcd, anyb, allb, eqb, hit;
  logic [3:0] cyc, nv, ln;
  logic [4:0] s5, d5;
  mopx_op_t op;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.mem_req = 1'b0;
    a = r.arg | {8'h0, r.nxor};
    sel = a[F_SEL +: 5];
    vr = a[F_VAR +: 3];
    lit = a[F_LIT +: 8];
    aux = a[F_AUX +: 5];
    cnt5 = lit[4:0];
    flen = (cnt5 == 5'h0) ? r.container_length[4:0] : cnt5;
    sv = src_val(r, sel);
    mask = {16'h0, lit};
    dispx = {{16{lit[7]}}, lit};
    op = mopx_op_t'(HWDATA[3:0]);
    start = r.dph && r.dwr && r.dadr == A_OP && r.st == ST_IDLE;
    bcd = sel == {S_NIB[4:3], N_BCN} && r.nib[N_CU] == CU_BCD;
    ln = r.nib[sel[2:0]];
    nv = ln;
    s5 = 5'({1'b0, ln} + {1'b0, lit[3:0]});
    d5 = 5'({1'b0, ln} - {1'b0, lit[3:0]});
    anyb = |(sv & mask);
    allb = (sv & mask) == mask;
    eqb = sv == mask;
    hit = 1'b0;
    wr_en = 1'b0;
    wr_sel = sel;
    wr_data = '0;
    skip = 1'b0;
    taken = 1'b0;
    refuse = 1'b0;
    cyc = C_BASE;
    // ----------------------------------------------------------------
    // Bus slave: address phase capture, reads take one wait state
    // ----------------------------------------------------------------
    if (HREADY)
    begin
      n.dph = HSEL && HTRANS[1];
      n.dwr = HWRITE;
      n.dadr = HADDR[7:0];
      n.hready = !(HSEL && HTRANS[1] && !HWRITE);
    end
    else
    begin
      n.hready = 1'b1;
    end
    if (r.dph && !r.dwr && !r.hready)
    begin
      n.hrdata = '0;
      if (r.dadr == A_ARG) n.hrdata = {8'h0, r.arg};
      else if (r.dadr == A_LIT24) n.hrdata = {8'h0, r.lit24};
      else if (r.dadr == A_STAT)
        n.hrdata = {24'h0, r.sp, r.ovr, r.refused, r.skip, r.st == ST_RUN};
      else if (r.dadr == A_X) n.hrdata = {8'h0, r.x};
      else if (r.dadr == A_Y) n.hrdata = {8'h0, r.y};
      else if (r.dadr == A_T) n.hrdata = {8'h0, r.t};
      else if (r.dadr == A_L) n.hrdata = {8'h0, r.l};
      else if (r.dadr == A_FA) n.hrdata = {8'h0, r.fa};
      else if (r.dadr == A_FB) n.hrdata = {8'h0, r.fb};
      else if (r.dadr == A_FL) n.hrdata = {8'h0, r.fl};
      else if (r.dadr == A_CPL) n.hrdata = {8'h0, r.container_length};
      else if (r.dadr == A_MAR) n.hrdata = {8'h0, r.mar};
      else if (r.dadr == A_TAS) n.hrdata = {8'h0, r.stack_top};
      else if (r.dadr == A_BR) n.hrdata = {8'h0, r.br};
      else if (r.dadr == A_LR) n.hrdata = {8'h0, r.lr};
      else if (r.dadr == A_NIB) n.hrdata = r.nib;
      else if (r.dadr == A_NXOR) n.hrdata = {16'h0, r.nxor};
      else if (r.dadr == A_CP) n.hrdata = {8'h0, r.cp};
    end
    // Software register writes other than the STAT overrun clear are honoured only while idle
    if (r.dph && r.dwr && r.st == ST_IDLE)
    begin
      if (r.dadr == A_ARG) n.arg = HWDATA[23:0];
      else if (r.dadr == A_LIT24) n.lit24 = HWDATA[23:0];
      else if (r.dadr == A_X) n.x = HWDATA[23:0];
      else if (r.dadr == A_Y) n.y = HWDATA[23:0];
      else if (r.dadr == A_T) n.t = HWDATA[23:0];
      else if (r.dadr == A_L) n.l = HWDATA[23:0];
      else if (r.dadr == A_FA) n.fa = HWDATA[23:0];
      else if (r.dadr == A_FB) n.fb = HWDATA[23:0];
      else if (r.dadr == A_FL) n.fl = HWDATA[23:0] & M16;
      else if (r.dadr == A_CPL) n.container_length = HWDATA[23:0] & M5;
      else if (r.dadr == A_MAR) n.mar = HWDATA[23:0];
      else if (r.dadr == A_TAS) n.stack_top = HWDATA[23:0];
      else if (r.dadr == A_BR) n.br = HWDATA[23:0];
      else if (r.dadr == A_LR) n.lr = HWDATA[23:0];
      else if (r.dadr == A_NIB) n.nib = HWDATA;
      else if (r.dadr == A_CP) n.cp = HWDATA[23:0] & M8;
    end
    if (r.dph && r.dwr && r.dadr == A_STAT && HWDATA[ST_OVR_B])
      n.ovr = 1'b0;
    // Set wins over the clear in the same cycle
    if (r.dph && r.dwr && r.dadr == A_OP && r.st == ST_RUN)
      n.ovr = 1'b1;
    // ----------------------------------------------------------------
    // Execution engine
    // ----------------------------------------------------------------
    if (r.st == ST_RUN)
    begin
      n.cnt = 4'(r.cnt - C_ONE);
      if (r.cnt == C_ONE)
      begin
        n.st = ST_IDLE;
        if (r.pend_rd) // Field read is right-justified, zero-filled
        begin
          wr_en = 1'b1;
          wr_sel = r.pend_sel;
          wr_data = MEM_RDATA & lowmask(r.pend_len);
        end
      end
    end
    if (start)
    begin
      n.nxor = '0; // Next-op mask is spent on this op only
      n.pend_rd = 1'b0;
      case (op)
        OP_MOVE:
        begin
          cyc = 4'(C_BASE + (bcd ? C_BCD : 4'h0) + (aux == S_MAR ? C_MAR : 4'h0));
          refuse = sel == S_UNIT || sel == S_CMD ||
                   sel == {S_NIB[4:3], N_CU} ||
                   (aux >= S_NIB && aux[2:0] <= N_OPERAND_STATE);
          wr_en = !refuse;
          wr_sel = aux;
          wr_data = sv;
          if (!refuse && sel == S_TAS && aux == S_MAR)
          begin
            n.stack_top = r.stk[4'(r.sp - 4'h1)]; // Return pops the stack
            n.sp = 4'(r.sp - 4'h1);
          end
        end
        OP_NIB:
        begin
          refuse = sel[2:0] <= N_CU;
          case (vr)
            3'h0: nv = lit[3:0];
            3'h1: nv = ln & lit[3:0];
            3'h2: nv = ln | lit[3:0];
            3'h3: nv = ln ^ lit[3:0];
            3'h4: nv = s5[3:0];
            3'h5:
            begin
              nv = s5[3:0];
              skip = s5[4];
            end
            3'h6: nv = d5[3:0];
            default:
            begin
              nv = d5[3:0];
              skip = d5[4];
            end
          endcase
          skip = skip && !refuse;
          wr_en = !refuse;
          wr_sel = {S_NIB[4:3], sel[2:0]};
          wr_data = {20'h0, nv};
          cyc = 4'(C_BASE + (skip ? C_TAKEN : 4'h0));
        end
        OP_BT0, OP_BT1:
        begin
          taken = sv[aux] == (op == OP_BT1);
          cyc = 4'(C_BASE + (bcd ? C_BCD : 4'h0) + (taken ? C_TAKEN : 4'h0));
        end
        OP_SKT:
        begin
          refuse = (vr == 3'h3 || vr == 3'h7) &&
                   sel >= S_NIB && sel[2:0] <= N_OPERAND_STATE;
          case (vr[1:0]) // Zero mask gives any false (true on variant 7), all true
            2'h0: hit = anyb;
            2'h1: hit = allb;
            2'h2: hit = eqb;
            // Zero mask never skips on variant 7, unlike variant 4
            default: hit = vr[2] ? (anyb || mask == '0) : allb;
          endcase
          skip = !refuse && (hit ^ vr[2]);
          if (vr[1:0] == 2'h3 && !refuse)
          begin
            wr_en = 1'b1;
            wr_data = sv & ~mask;
          end
          cyc = 4'(C_BASE + (bcd ? C_BCD : 4'h0) + (skip ? C_TAKEN : 4'h0));
        end
        OP_MEM:
        begin
          cyc = C_MEM;
          n.mem_req = 1'b1;
          n.mem_wr = a[F_DIR];
          n.mem_dir = a[F_ROT];
          n.mem_addr = r.fa;
          n.mem_len = flen;
          n.mem_wdata = sv & lowmask(flen);
          n.pend_rd = !a[F_DIR];
          n.pend_sel = sel;
          n.pend_len = flen;
          if (vr == 3'h1 || vr == 3'h3) n.fa = 24'(r.fa + flen);
          if (vr == 3'h4 || vr == 3'h5 || vr == 3'h7)
            n.fa = 24'(r.fa - flen);
          if (vr == 3'h2 || vr == 3'h4) n.fl = 24'(r.fl + flen) & M16;
          if (vr == 3'h3 || vr == 3'h6 || vr == 3'h7) // FL stops at zero
            n.fl = (r.fl < {19'h0, flen}) ? '0 : 24'(r.fl - flen);
        end
        OP_L8:
        begin
          refuse = sel > S_CP;
          wr_en = !refuse;
          wr_data = {16'h0, lit};
          cyc = 4'(C_BASE + (sel == S_MAR ? C_MAR : 4'h0));
        end
        OP_L24:
        begin
          refuse = sel > S_TAS;
          wr_en = !refuse;
          wr_data = r.lit24;
          cyc = C_L24;
        end
        OP_SHT:
        begin
          refuse = aux >= S_NIB && aux[2:0] <= N_OPERAND_STATE;
          wr_en = !refuse;
          wr_sel = aux;
          wr_data = 24'({8'h0, r.t} << flen);
          cyc = 4'(C_SHT + (aux == S_MAR ? C_MAR : 4'h0));
        end
        OP_EXT:
        begin
          wr_en = 1'b1;
          wr_sel = {3'h0, vr[1:0]}; // Codes 0-3 pick X, Y, T, L
          wr_data = rotl(r.t, cnt5) & lowmask(aux);
          cyc = C_SHT;
        end
        OP_BR:
        begin
          taken = 1'b1;
          cyc = C_BR;
        end
        OP_CALL:
        begin
          taken = 1'b1;
          n.stk[r.sp] = r.stack_top;
          n.stack_top = r.mar;
          n.sp = 4'(r.sp + 4'h1);
          cyc = C_CALL;
        end
        OP_SXY:
        begin
          wr_en = 1'b1;
          wr_sel = a[F_YSEL] ? S_Y : S_X;
          sv = a[F_YSEL] ? r.y : r.x;
          if (a[F_ROT]) // Right rotation is the complementary left one
            wr_data = a[F_DIR] ? rotl(sv, 5'(FULL_W - cnt5)) : rotl(sv, cnt5);
          else
            wr_data = a[F_DIR] ? sv >> cnt5 : 24'({8'h0, sv} << cnt5);
          cyc = C_SHT;
        end
        OP_DSH:
        begin
          // Counts other than one are undefined; one bit is always moved
          {n.x, n.y} = a[F_DIR] ? {r.x, r.y} >> 1 : {r.x, r.y} << 1;
          cyc = C_DSH;
        end
        default: cyc = C_BASE;
      endcase
      n.st = ST_RUN;
      n.cnt = cyc; // Busy stands for the whole op time
      n.skip = skip || taken;
      n.refused = refuse;
      if (skip) n.mar = 24'(r.mar + MAR_STEP);
      else if (taken && op != OP_BR && op != OP_CALL)
        n.mar = 24'(r.mar + dispx);
      else if (taken)
        n.mar = 24'(r.mar + dispx);
    end
    // ----------------------------------------------------------------
    // Single register write port
    // ----------------------------------------------------------------
    if (wr_en)
    begin
      wr_data = wr_data & wmask(wr_sel);
      if (wr_sel >= S_NIB) n.nib[wr_sel[2:0]] = wr_data[3:0];
      else if (wr_sel == S_X) n.x = wr_data;
      else if (wr_sel == S_Y) n.y = wr_data;
      else if (wr_sel == S_T) n.t = wr_data;
      else if (wr_sel == S_L) n.l = wr_data;
      else if (wr_sel == S_MAR) n.mar = wr_data;
      else if (wr_sel == S_BR) n.br = wr_data;
      else if (wr_sel == S_LR) n.lr = wr_data;
      else if (wr_sel == S_FA) n.fa = wr_data;
      else if (wr_sel == S_FB) n.fb = wr_data;
      else if (wr_sel == S_FL) n.fl = wr_data;
      else if (wr_sel == S_TAS) n.stack_top = wr_data;
      else if (wr_sel == S_CP) n.cp = wr_data;
      else if (wr_sel == S_CPL) n.container_length = wr_data;
      else if (wr_sel == S_NXT) n.nxor = n.nxor | wr_data[15:0];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r <= '0;
      r.hready <= 1'b1;
      r.st <= ST_IDLE;
    end
    else if (CE)
    begin
      r <= n;
    end
  end

  assign HREADYOUT = r.hready;
  assign HRESP = 1'b0;
  assign HRDATA = r.hrdata;
  assign MEM_REQ = r.mem_req;
  assign MEM_WRITE = r.mem_wr;
  assign MEM_DIR = r.mem_dir;
  assign MEM_ADDR = r.mem_addr;
  assign MEM_LEN = r.mem_len;
  assign MEM_WDATA = r.mem_wdata;
  assign BUSY = r.st == ST_RUN;
endmodule // mopx_unit
`default_nettype wire

// >>> sim/mopx_mem.sv
/* Field memory model: a read returns a pattern of the address.
   Assumes one request at a time; data stands only in its window. */
`timescale 1ns/1ps
`default_nettype none
module mopx_mem (
  input wire logic CLK,
  input wire logic MEM_REQ,
  input wire logic MEM_WRITE,
  input wire logic [23:0] MEM_ADDR,
  input wire logic [4:0] MEM_LEN,
  input wire logic [23:0] MEM_WDATA,
  output logic [23:0] MEM_RDATA
);
  logic [23:0] addr_reg, wdat_reg;
  logic [4:0] len_reg;
  logic [2:0] win_reg = 3'h0;
  initial MEM_RDATA = 24'h0;
  always @(posedge CLK)
  begin
    if (MEM_REQ)
    begin
      addr_reg <= MEM_ADDR;
      len_reg <= MEM_LEN;
      win_reg <= 3'h7;
    end
    else if (win_reg != 3'h0)
      win_reg <= win_reg - 3'h1;
    if (MEM_REQ && MEM_WRITE)
      wdat_reg <= MEM_WDATA;
    // Outside the window the lines toggle so stale data never matches
    MEM_RDATA <= (win_reg != 3'h0) ? addr_reg ^ 24'h5A5A5A : ~MEM_RDATA;
  end
endmodule // mopx_mem
`default_nettype wire

// >>> sim/mopx_properties.sv
/* Port checker for mopx_unit, bound to its ports.
   Assumes CE high and HREADY fed from HREADYOUT. */
`timescale 1ns/1ps
`default_nettype none
module mopx_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic MEM_REQ,
  input wire logic BUSY
);
  logic [3:0] run_reg;
  logic mem_reg;
  // Run length counted here, since a repetition cannot span eight clocks
  always_ff @(posedge CLK)
  begin
    run_reg <= (RST || !BUSY) ? 4'h0 : run_reg + 4'h1;
    mem_reg <= !RST && BUSY && (mem_reg || MEM_REQ);
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  property p_rd;
    HSEL && HTRANS[1] && !HWRITE && HREADY |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr; HSEL && HTRANS[1] && HWRITE && HREADY |=> HREADYOUT;
  endproperty
  a_wr: assert property (p_wr) else $error("write waited");
  property p_req; MEM_REQ |=> !MEM_REQ; endproperty
  a_req: assert property (p_req) else $error("request too long");
  property p_reqb; MEM_REQ |-> BUSY; endproperty
  a_reqb: assert property (p_reqb) else $error("request idle");
  property p_hold; $rose(BUSY) |=> BUSY; endproperty
  a_hold: assert property (p_hold) else $error("op too short");
  property p_min; $fell(BUSY) |-> run_reg >= 4'h2; endproperty
  a_min: assert property (p_min) else $error("run under two");
  property p_max; BUSY |-> run_reg < 4'h8; endproperty
  a_max: assert property (p_max) else $error("run over eight");
  property p_mem; $fell(BUSY) && mem_reg |-> run_reg == 4'h8; endproperty
  a_mem: assert property (p_mem) else $error("field move time");
endmodule // mopx_props
bind mopx_unit mopx_props u_props (.CLK(CLK), .RST(RST), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .MEM_REQ(MEM_REQ), .BUSY(BUSY));
`default_nettype wire

// >>> sim/testbench.sv
/* Bench for mopx_unit: AHB-Lite tasks and op sequences.
   Assumes the field memory model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mopx_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, busy;
  logic hresp, mreq, mwr, sk;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [23:0] maddr, mwd, mrd, x, m;
  logic [4:0] mlen, s, df;
  logic [3:0] r, e;
  int bad_count = 0, cmp_count = 0;
  mopx_unit dut (.CLK(clk), .RST(rst), .CE(1'b1), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp),
    .HRDATA(hrdata), .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_DIR(),
    .MEM_ADDR(maddr), .MEM_LEN(mlen), .MEM_WDATA(mwd),
    .MEM_RDATA(mrd), .BUSY(busy));
  mopx_mem mem (.CLK(clk), .MEM_REQ(mreq), .MEM_WRITE(mwr),
    .MEM_ADDR(maddr), .MEM_LEN(mlen), .MEM_WDATA(mwd), .MEM_RDATA(mrd));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    cmp_count++;
    if (g !== w)
    begin
      bad_count++;
      $display("mismatch %0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(negedge clk); while (hrdy !== 1'b1);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] u;
    bus(1'b1, a, wd, u);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] w);
    logic [31:0] u;
    bus(1'b0, a, 32'h0, u);
    chk(u, w);
  endtask
  // Start an op and count its busy cycles against the expected time
  task automatic op(input logic [3:0] c, input logic [31:0] g, input int t);
    int k;
    wr(A_ARG, g);
    wr(A_OP, {28'h0, c});
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (busy !== 1'b1 && k < 4);
    k = 0;
    while (busy === 1'b1)
    begin
      @(negedge clk);
      k++;
    end
    chk(k, t);
    @(posedge clk);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      r = i[3] ? 4'h3 : 4'hC;
      s = r + 4'h6;
      df = r - 4'h6;
      case (i[2:0])
        3'h0: e = 4'h6;
        3'h1: e = r & 4'h6;
        3'h2: e = r | 4'h6;
        3'h3: e = r ^ 4'h6;
        3'h4, 3'h5: e = s[3:0];
        default: e = df[3:0];
      endcase
      sk = (i[2:0] == 3'h5 && s[4]) || (i[2:0] == 3'h7 && df[4]);
      wr(A_NIB, {8'h0, r, 20'h0});
      wr(A_MAR, 32'h0);
      op(OP_NIB, {20'h6, i[2:0], 5'h1D}, sk ? 4 : 2);
      rc(A_NIB, {8'h0, e, 20'h0});
      rc(A_MAR, {31'h0, sk});
    end
    for (int i = 0; i < 24; i++)
    begin
      x = (i > 15) ? 24'h13 : 24'hF3;
      m = (i > 7 && i < 16) ? 24'h0 : 24'h13;
      case (i[2:0])
        3'h0: sk = |(x & m);
        3'h1, 3'h3: sk = (x & m) == m;
        3'h2: sk = x == m;
        3'h5: sk = (x & m) != m;
        3'h6: sk = x != m;
        3'h7: sk = ~|(x & m) && m != 24'h0;
        default: sk = ~|(x & m);
      endcase
      wr(A_X, {8'h0, x});
      wr(A_MAR, 32'h0);
      op(OP_SKT, {16'h0, m[7:0], i[2:0], 5'h0}, sk ? 4 : 2);
      rc(A_MAR, {31'h0, sk});
      rc(A_X, {8'h0, (i[1:0] == 2'h3) ? x & ~m : x});
    end
    for (int i = 0; i < 4; i++)
    begin
      sk = i[1] ^ i[0];
      wr(A_X, 32'h10);
      wr(A_MAR, 32'h10);
      op(i[1] ? OP_BT1 : OP_BT0, {15'h2, i[0], 16'hFE00}, sk ? 4 : 2);
      rc(A_MAR, sk ? 32'hE : 32'h10);
    end
    wr(A_MAR, 32'h100);
    op(OP_BR, 32'h0500, 4);
    rc(A_MAR, 32'h105);
    op(OP_CALL, 32'h8000, 5);
    rc(A_MAR, 32'h85);
    rc(A_TAS, 32'h105);
    op(OP_L8, 32'hA501, 2);
    rc(A_Y, 32'hA5);
    op(OP_L8, 32'h0704, 4);
    wr(A_LIT24, 32'hABCDEF);
    op(OP_L24, 32'h9, 6);
    rc(A_FL, 32'hCDEF);
    op(OP_MOVE, 32'h10, 2);
    rc(A_X, 32'h0);
    op(OP_MOVE, 32'hD, 2);
    rc(A_STAT, 32'h14);
    wr(A_X, 32'h3);
    op(OP_MOVE, 32'h100000, 2);
    op(OP_L8, 32'hA001, 2);
    rc(A_L, 32'hA0);
    wr(A_X, 32'h800001);
    op(OP_SXY, 32'h400100, 3);
    rc(A_X, 32'h3);
    op(OP_SXY, 32'h200100, 3);
    wr(A_Y, 32'h1);
    op(OP_SXY, 32'hE00100, 3);
    op(OP_SXY, 32'hA00000, 3);
    op(OP_DSH, 32'h0100, 6);
    rc(A_X, 32'h3);
    rc(A_Y, 32'h0);
    wr(A_T, 32'h00F00F);
    op(OP_SHT, 32'h0800, 3);
    rc(A_X, 32'hF00F00);
    wr(A_T, 32'h123456);
    op(OP_EXT, 32'h000C0820, 3);
    rc(A_Y, 32'h612);
    wr(A_FA, 32'h100);
    op(OP_MEM, 32'h0821, 8);
    rc(A_Y, 32'h5A);
    rc(A_FA, 32'h108);
    wr(A_CPL, 32'hC);
    wr(A_X, 32'h123456);
    op(OP_MEM, 32'h200000, 8);
    chk({8'h0, mem.wdat_reg}, 32'h456);
    wr(A_NIB, 32'h10001);
    op(OP_SKT, 32'h0118, 5);
    op(OP_NIB, 32'h0F1C, 2);
    op(OP_SKT, 32'h0178, 3);
    rc(A_NIB, 32'h10001);
    rc(A_STAT, 32'h14);
    close_out();
  end
endmodule // testbench
`default_nettype wire
